/* hdl/fnpi_blink.sv */
// Purpose: indicator blink divider
// Assumes: HALF is half the blink period in clock cycles
// Notes:   restarting on run_i low keeps every blink phase full length
module fnpi_blink #(
  parameter int unsigned HALF = 50_000_000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic run_i,
  output logic      blink_o
);

  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_r;

  initial begin
    if (HALF < 1) begin
      $error("blink half period must be at least one cycle");
    end
  end

  // equal counts high and low give an even duty cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r   <= '0;
      blink_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r   <= '0;
      blink_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r   <= '0;
      blink_o <= ~blink_o;
    end else begin
      cnt_r   <= cnt_r + 1'b1;
    end
  end

endmodule

/* hdl/fnpi_core.sv */
// Purpose: fieldbus node process image, parameters, diagnostics and indicators
// Assumes: link and record signals come from protocol logic on clk_i
// Notes:   head presence and trigger are pins and are synchronised first
module fnpi_core
  import fnpi_pkg::*;
#(
  parameter int unsigned MAX_HEADS   = 8,
  parameter int unsigned BLINK_HALF  = BLINK_HALF_CYCLES,
  parameter bit          DIN_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // link state from protocol logic
  input  wire logic                 link_up_i,
  input  wire logic                 rec_done_i,
  // parameter records
  input  wire logic                 rec_valid_i,
  input  wire logic [3:0]           rec_slot_i,
  input  wire logic [3:0]           rec_id_i,
  input  wire logic [15:0]          rec_data_i,
  // pins
  input  wire logic [MAX_HEADS-1:0] head_present_i,
  input  wire logic                 trigger_i,
  // head and node measurements
  input  wire logic                 head_wr_i,
  input  wire logic [3:0]           head_slot_i,
  input  wire logic                 head_fault_i,
  input  wire logic [15:0]          head_obj_i,
  input  wire logic [15:0]          head_int_i,
  input  wire logic [15:0]          node_temp_i,
  input  wire logic                 node_fault_i,
  // process image read
  input  wire logic                 img_rd_i,
  input  wire logic [3:0]           img_slot_i,
  input  wire logic                 img_word_i,
  output logic                      img_valid_o,
  output logic                      img_err_o,
  output logic [15:0]               img_data_o,
  // status
  output logic                      ready_o,
  output logic [3:0]                heads_cnt_o,
  output logic                      led_yellow_o,
  output logic                      led_green_o,
  output logic [MAX_HEADS:0]        diag_fwd_o,
  // analog output one
  output logic [2:0]                ao1_mode_o,
  output logic [15:0]               ao1_bot_o,
  output logic [15:0]               ao1_top_o,
  output logic [15:0]               ao1_temp_o,
  // analog output two
  output logic [2:0]                ao2_mode_o,
  output logic [15:0]               ao2_bot_o,
  output logic [15:0]               ao2_top_o,
  output logic [15:0]               ao2_temp_o
);

  localparam int unsigned AW = (MAX_HEADS > 1) ? $clog2(MAX_HEADS) : 1;
  localparam logic [2:0] SETTLE_LAST = 3'(DISC_SETTLE_CYCLES - 1);

  initial begin
    if (MAX_HEADS < 1 || MAX_HEADS > 8) begin
      $error("MAX_HEADS must lie between 1 and 8");
    end
  end

  fnpi_state_e state_r;

  logic [MAX_HEADS-1:0] pres_s1_r;
  logic [MAX_HEADS-1:0] pres_s2_r;
  logic                 trig_s1_r;
  logic                 trig_s2_r;
  logic [2:0]           settle_r;
  logic [AW:0]          clr_r;

  // node parameters
  logic        unit_r;
  logic        pdiag_r;
  logic        fault_pol_r;
  logic        node_diag_r;
  logic [3:0]  ao1_head_r;
  logic [3:0]  ao2_head_r;
  logic        ao1_type_r;
  logic        ao2_type_r;

  // module parameters
  logic [3:0]           head_num_r [MAX_HEADS];
  logic [MAX_HEADS-1:0] mdiag_r;
  logic [MAX_HEADS-1:0] mfault_ov_r;
  logic [MAX_HEADS-1:0] mfault_val_r;
  logic [MAX_HEADS-1:0] mfault_r;

  // image access
  logic              ram_we;
  logic [AW-1:0]     ram_waddr;
  logic [31:0]       ram_wdata;
  logic [31:0]       ram_rdata;
  logic              rd_p1_r;
  logic              rd_err_p1_r;
  logic              rd_node_p1_r;
  logic              rd_word_p1_r;
  logic              blink;

  // leading run of present heads: attachment is contiguous from slot 1
  function automatic logic [3:0] count_leading(input logic [MAX_HEADS-1:0] p);
    logic [3:0] n;
    logic       run;
    n   = 4'h0;
    run = 1'b1;
    for (int i = 0; i < MAX_HEADS; i++) begin
      run = run & p[i];
      if (run) begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  function automatic logic [15:0] to_unit(input logic [15:0] c, input logic u);
    int signed f;
    f = (int'(signed'(c)) * F_MUL) / F_DIV + F_OFS;
    return (u == UNIT_CELSIUS) ? c : f[15:0];
  endfunction

  // pin synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pres_s1_r <= '0;
      pres_s2_r <= '0;
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
    end else begin
      pres_s1_r <= head_present_i;
      pres_s2_r <= pres_s1_r;
      trig_s1_r <= trigger_i;
      trig_s2_r <= trig_s1_r;
    end
  end

  // node life cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r     <= ST_OFF;
      settle_r    <= '0;
      clr_r       <= '0;
      heads_cnt_o <= 4'h0;
    end else if (!link_up_i) begin
      state_r  <= ST_OFF;
      settle_r <= '0;
      clr_r    <= '0;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          state_r <= ST_DISCOVER;
        end
        ST_DISCOVER: begin
          // image is cleared while the presence pins settle
          if (clr_r < (AW + 1)'(MAX_HEADS)) begin
            clr_r <= clr_r + 1'b1;
          end
          if (settle_r != SETTLE_LAST) begin
            settle_r <= settle_r + 1'b1;
          end else if (clr_r >= (AW + 1)'(MAX_HEADS)) begin
            heads_cnt_o <= count_leading(pres_s2_r);
            state_r     <= ST_WAIT_PARAM;
          end
        end
        ST_WAIT_PARAM: begin
          if (rec_done_i) begin
            state_r <= ST_EXCHANGE;
          end
        end
        ST_EXCHANGE: begin
          state_r <= ST_EXCHANGE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (state_r == ST_EXCHANGE) && link_up_i;
    end
  end

  // node records; the rail variant accepts the unit alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_r      <= UNIT_CELSIUS;
      pdiag_r     <= 1'b0;
      fault_pol_r <= FAULT_ZERO;
      node_diag_r <= 1'b0;
      ao1_bot_o   <= TEMP_BOT_RST;
      ao1_top_o   <= TEMP_TOP_RST;
      ao2_bot_o   <= TEMP_BOT_RST;
      ao2_top_o   <= TEMP_TOP_RST;
      ao1_head_r  <= HEAD_NUM_RST;
      ao2_head_r  <= HEAD_NUM_RST;
      ao1_type_r  <= SRC_INTERNAL;
      ao2_type_r  <= SRC_INTERNAL;
      ao1_mode_o  <= AO1_TRISTATE;
      ao2_mode_o  <= AO2_TRISTATE;
    end else if (rec_valid_i && rec_slot_i == 4'h0) begin
      if (rec_id_i == PID_UNIT) begin
        unit_r <= rec_data_i[0];
      end else if (!DIN_VARIANT) begin
        unique case (rec_id_i)
          PID_PDIAG:     pdiag_r     <= rec_data_i[0];
          PID_FAULT:     fault_pol_r <= rec_data_i[0];
          PID_NODE_DIAG: node_diag_r <= rec_data_i[0];
          PID_AO1_BOT:   ao1_bot_o   <= rec_data_i;
          PID_AO1_TOP:   ao1_top_o   <= rec_data_i;
          PID_AO2_BOT:   ao2_bot_o   <= rec_data_i;
          PID_AO2_TOP:   ao2_top_o   <= rec_data_i;
          PID_AO1_HEAD:  ao1_head_r  <= rec_data_i[3:0];
          PID_AO2_HEAD:  ao2_head_r  <= rec_data_i[3:0];
          PID_AO1_TYPE:  ao1_type_r  <= rec_data_i[0];
          PID_AO2_TYPE:  ao2_type_r  <= rec_data_i[0];
          PID_AO1_MODE: begin
            // unknown codes fall back to the safe disabled mode
            ao1_mode_o <= (rec_data_i[2:0] > AO1_TRISTATE) ? AO1_TRISTATE : rec_data_i[2:0];
          end
          PID_AO2_MODE: begin
            ao2_mode_o <= (rec_data_i[2:0] > AO2_TRISTATE) ? AO2_TRISTATE : rec_data_i[2:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // per-module records and fault flags
  for (genvar g = 0; g < MAX_HEADS; g++) begin : g_mod
    logic mod_rec;
    logic mod_wr;
    assign mod_rec = rec_valid_i && (rec_slot_i == 4'(g + 1));
    assign mod_wr  = head_wr_i && (head_slot_i == 4'(g + 1)) && (4'(g + 1) <= heads_cnt_o);

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        head_num_r[g]   <= HEAD_NUM_RST;
        mdiag_r[g]      <= 1'b1;
        mfault_ov_r[g]  <= 1'b0;
        mfault_val_r[g] <= FAULT_ZERO;
      end else if (mod_rec) begin
        unique case (rec_id_i)
          PID_HEAD_NUM: head_num_r[g] <= rec_data_i[3:0];
          PID_MOD_DIAG: mdiag_r[g]    <= rec_data_i[0];
          PID_MOD_FAULT: begin
            mfault_ov_r[g]  <= 1'b1;
            mfault_val_r[g] <= rec_data_i[0];
          end
          default: begin
          end
        endcase
      end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        mfault_r[g] <= 1'b0;
      end else if (mod_wr) begin
        mfault_r[g] <= head_fault_i;
      end
    end
  end

  // effective fault policy of the writing module
  logic [AW-1:0] wr_idx;
  logic          wr_ok;
  logic          wr_pol;
  logic [15:0]   obj_u;
  logic [15:0]   int_u;

  assign wr_idx = AW'(head_slot_i - 4'h1);
  assign wr_ok  = head_wr_i && (head_slot_i != 4'h0) && (head_slot_i <= heads_cnt_o);
  assign wr_pol = mfault_ov_r[wr_idx] ? mfault_val_r[wr_idx] : fault_pol_r;
  assign obj_u  = to_unit(head_obj_i, unit_r);
  assign int_u  = to_unit(head_int_i, unit_r);

  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = wr_idx;
    ram_wdata = {obj_u, int_u};
    if (state_r == ST_DISCOVER) begin
      ram_we    = clr_r < (AW + 1)'(MAX_HEADS);
      ram_waddr = clr_r[AW-1:0];
      ram_wdata = '0;
    end else if (wr_ok) begin
      if (head_fault_i) begin
        // zero policy clears at once, hold policy skips the write
        ram_we    = (wr_pol == FAULT_ZERO);
        ram_wdata = '0;
      end else begin
        ram_we = 1'b1;
      end
    end
  end

  fnpi_image_ram #(
    .WIDTH (32),
    .DEPTH (MAX_HEADS),
    .AW    (AW)
  ) u_image (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .raddr_i (AW'(img_slot_i - 4'h1)),
    .rdata_o (ram_rdata)
  );

  // analog sources follow the head number, not the slot
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ao1_temp_o <= ZERO16;
      ao2_temp_o <= ZERO16;
    end else if (ram_we && state_r != ST_DISCOVER) begin
      if (head_num_r[wr_idx] == ao1_head_r) begin
        ao1_temp_o <= (ao1_type_r == SRC_INTERNAL) ? ram_wdata[15:0] : ram_wdata[31:16];
      end
      if (head_num_r[wr_idx] == ao2_head_r) begin
        ao2_temp_o <= (ao2_type_r == SRC_INTERNAL) ? ram_wdata[15:0] : ram_wdata[31:16];
      end
    end
  end

  // image read pipeline: slot 0 is the node itself
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_p1_r      <= 1'b0;
      rd_err_p1_r  <= 1'b0;
      rd_node_p1_r <= 1'b0;
      rd_word_p1_r <= 1'b0;
      img_valid_o  <= 1'b0;
      img_err_o    <= 1'b0;
      img_data_o   <= ZERO16;
    end else begin
      rd_p1_r      <= img_rd_i;
      rd_err_p1_r  <= (state_r != ST_EXCHANGE) || (img_slot_i > heads_cnt_o);
      rd_node_p1_r <= img_slot_i == 4'h0;
      rd_word_p1_r <= img_word_i;
      img_valid_o  <= rd_p1_r;
      img_err_o    <= rd_p1_r && rd_err_p1_r;
      if (!rd_p1_r || rd_err_p1_r) begin
        img_data_o <= ZERO16;
      end else if (rd_node_p1_r) begin
        img_data_o <= (rd_word_p1_r == WORD_OBJ) ? to_unit(node_temp_i, unit_r)
                                                 : {15'h0000, trig_s2_r};
      end else begin
        img_data_o <= (rd_word_p1_r == WORD_OBJ) ? ram_rdata[31:16] : ram_rdata[15:0];
      end
    end
  end

  // diagnostics forwarding
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      diag_fwd_o <= '0;
    end else begin
      diag_fwd_o[0] <= node_fault_i && node_diag_r;
      for (int i = 0; i < MAX_HEADS; i++) begin
        diag_fwd_o[i+1] <= mfault_r[i] && mdiag_r[i] && pdiag_r;
      end
    end
  end

  fnpi_blink #(
    .HALF (BLINK_HALF)
  ) u_blink (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (state_r == ST_DISCOVER || state_r == ST_WAIT_PARAM),
    .blink_o (blink)
  );

  // indicators
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      led_yellow_o <= 1'b0;
      led_green_o  <= 1'b0;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          led_yellow_o <= 1'b0;
          led_green_o  <= 1'b0;
        end
        ST_DISCOVER, ST_WAIT_PARAM: begin
          led_yellow_o <= 1'b1;
          led_green_o  <= blink;
        end
        ST_EXCHANGE: begin
          led_yellow_o <= 1'b1;
          led_green_o  <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* hdl/fnpi_image_ram.sv */
// Purpose: process image store, one word per head
// Assumes: one write and one read per cycle
// Notes:   read data come from a register, one cycle after the address
module fnpi_image_ram #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // write port
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > (2 ** AW)) begin
      $error("image ram depth does not fit its address");
    end
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

/* hdl/fnpi_pkg.sv */
// Purpose: constants, encodings and states of the image core
// Assumes: heads give signed 16-bit tenths of a degree Celsius
// Notes:   record ids and mode codes are shared with the parameter source
// Behaviour
// - awaiting parameters: yellow steady, green 1 Hz
// - exchange both on, no link both off
// - discover attached heads, build process image
// - object and internal temperature per head
// - slot 0: node temperature, trigger, node parameters
// - slots 1..8 follow physical attachment order
// - every module has a diagnostics enable setting
// - ready and cyclic data only after records
// - module setting overrides node default, that module only
// - periphery diagnostics option gates module diagnostics
// - module fault: zero data or hold last
// - Celsius/Fahrenheit unit; rail variant unit only
// - analog outputs have bottom and top temperature
// - analog source head number and source type
// - output one: J, K, R, S, 0-5V, 0-10V, tristate
// - output two: 0-20mA, 4-20mA, 0-5V, 0-10V, tristate
package fnpi_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_DISCOVER,
    ST_WAIT_PARAM,
    ST_EXCHANGE
  } fnpi_state_e;

  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned DISC_SETTLE_CYCLES = 4;

  // record parameter ids, slot 0
  localparam logic [3:0] PID_UNIT      = 4'h0;
  localparam logic [3:0] PID_PDIAG     = 4'h1;
  localparam logic [3:0] PID_FAULT     = 4'h2;
  localparam logic [3:0] PID_AO1_BOT   = 4'h3;
  localparam logic [3:0] PID_AO1_TOP   = 4'h4;
  localparam logic [3:0] PID_AO2_BOT   = 4'h5;
  localparam logic [3:0] PID_AO2_TOP   = 4'h6;
  localparam logic [3:0] PID_AO1_HEAD  = 4'h7;
  localparam logic [3:0] PID_AO1_TYPE  = 4'h8;
  localparam logic [3:0] PID_AO1_MODE  = 4'h9;
  localparam logic [3:0] PID_AO2_HEAD  = 4'hA;
  localparam logic [3:0] PID_AO2_TYPE  = 4'hB;
  localparam logic [3:0] PID_AO2_MODE  = 4'hC;
  localparam logic [3:0] PID_NODE_DIAG = 4'hD;
  // record parameter ids, slots 1..8
  localparam logic [3:0] PID_HEAD_NUM  = 4'h0;
  localparam logic [3:0] PID_MOD_DIAG  = 4'h1;
  localparam logic [3:0] PID_MOD_FAULT = 4'h2;

  // analog output one modes
  localparam logic [2:0] thermocouple_type_j_mode = 3'h0;
  localparam logic [2:0] thermocouple_type_k_mode = 3'h1;
  localparam logic [2:0] thermocouple_type_r_mode = 3'h2;
  localparam logic [2:0] thermocouple_type_s_mode = 3'h3;
  localparam logic [2:0] AO1_V0_5                 = 3'h4;
  localparam logic [2:0] AO1_V0_10                = 3'h5;
  localparam logic [2:0] AO1_TRISTATE             = 3'h6;
  // analog output two modes
  localparam logic [2:0] AO2_MA0_20    = 3'h0;
  localparam logic [2:0] AO2_MA4_20    = 3'h1;
  localparam logic [2:0] AO2_V0_5      = 3'h2;
  localparam logic [2:0] AO2_V0_10     = 3'h3;
  localparam logic [2:0] AO2_TRISTATE  = 3'h4;

  // field values
  localparam logic UNIT_CELSIUS  = 1'b0;
  localparam logic FAULT_ZERO    = 1'b0;
  localparam logic SRC_INTERNAL  = 1'b0;
  localparam logic WORD_OBJ      = 1'b0;

  // reset values
  localparam logic [15:0] TEMP_BOT_RST = 16'h0000;
  localparam logic [15:0] TEMP_TOP_RST = 16'h7530;
  localparam logic [3:0]  HEAD_NUM_RST = 4'h1;
  localparam logic [15:0] ZERO16       = 16'h0000;

  // fahrenheit in tenths: f = c * 9 / 5 + 320
  localparam int signed F_MUL = 9;
  localparam int signed F_DIV = 5;
  localparam int signed F_OFS = 320;

endpackage

/* tb/fnpi_core_checker.sv */
// Purpose: port-level assertions for the image core
// Assumes: DIN_VARIANT left at 0
// Notes:   blink bound allows one extra cycle for the restart phase
module fnpi_core_checker
  import fnpi_pkg::*;
#(
  parameter int unsigned MAX_HEADS  = 8,
  parameter int unsigned BLINK_HALF = 4
) (
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // controller side
  input wire logic               link_up_i,
  input wire logic               rec_done_i,
  input wire logic               rec_valid_i,
  input wire logic [3:0]         rec_slot_i,
  input wire logic [3:0]         rec_id_i,
  input wire logic [15:0]        rec_data_i,
  input wire logic               node_fault_i,
  input wire logic               img_rd_i,
  // watched outputs
  input wire logic               img_valid_o,
  input wire logic               img_err_o,
  input wire logic [15:0]        img_data_o,
  input wire logic               ready_o,
  input wire logic               led_yellow_o,
  input wire logic               led_green_o,
  input wire logic [MAX_HEADS:0] diag_fwd_o,
  input wire logic [2:0]         ao1_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // run length of the green level while waiting
  logic [31:0] hold_r;
  logic        grn_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_r <= 32'h0000_0000;
      grn_r  <= 1'b0;
    end else begin
      grn_r  <= led_green_o;
      hold_r <= (!led_yellow_o || ready_o || led_green_o != grn_r) ? 32'h0000_0001 : hold_r + 1;
    end
  end
  sequence s_dark;
    !link_up_i [*3];
  endsequence
  sequence s_rd_idle;
    img_rd_i ##1 !ready_o [*3];
  endsequence
  a_blink_even : assert property (hold_r <= BLINK_HALF + 1)
    else $error("green level held too long");
  a_exch_leds : assert property (ready_o |-> led_yellow_o && led_green_o)
    else $error("leds not both on in exchange");
  a_dark_leds : assert property (s_dark |-> !led_yellow_o && !led_green_o)
    else $error("leds lit without link");
  a_img_lat : assert property (img_rd_i |-> ##2 img_valid_o)
    else $error("image answer late");
  a_err_zero : assert property (img_valid_o && img_err_o |-> img_data_o == 16'h0000)
    else $error("error answer carries data");
  a_idle_err : assert property (s_rd_idle |-> $past(img_err_o))
    else $error("data given before exchange");
  a_ready_rec : assert property ($rose(ready_o) |-> $past(rec_done_i, 2))
    else $error("ready without records done");
  a_diag_node : assert property (diag_fwd_o[0] |-> $past(node_fault_i))
    else $error("node diagnostic without fault");
  a_ao1_mode : assert property (rec_valid_i && rec_slot_i == 4'h0
    && rec_id_i == PID_AO1_MODE && rec_data_i[2:0] <= AO1_TRISTATE
    |=> ao1_mode_o == $past(rec_data_i[2:0]))
    else $error("output one mode not taken");
endmodule

bind fnpi_core fnpi_core_checker #(.MAX_HEADS(MAX_HEADS), .BLINK_HALF(BLINK_HALF)) u_chk (.*);

/* tb/fnpi_ctrl_model.sv */
// Purpose: behavioural controller for link and records
// Assumes: records are one-cycle strobes on the core clock
// Notes:   released data shows its inverse so a stale value never passes
module fnpi_ctrl_model
  import fnpi_pkg::*;
(
  // clock
  input  wire logic   clk_i,
  // link
  output logic        link_up_o,
  output logic        rec_done_o,
  // records
  output logic        rec_valid_o,
  output logic [3:0]  rec_slot_o,
  output logic [3:0]  rec_id_o,
  output logic [15:0] rec_data_o
);
  initial {link_up_o, rec_done_o, rec_valid_o, rec_slot_o, rec_id_o, rec_data_o} = '0;
  task automatic set_link(input logic up, input logic done);
    @(posedge clk_i);
    link_up_o  <= up;
    rec_done_o <= done;
  endtask
  // gap plays a slow controller
  task automatic send_rec(input logic [3:0] s, input logic [3:0] id,
                          input logic [15:0] d, input int gap);
    @(posedge clk_i);
    {rec_valid_o, rec_slot_o, rec_id_o, rec_data_o} <= {1'b1, s, id, d};
    @(posedge clk_i);
    rec_valid_o <= 1'b0;
    rec_data_o  <= ~d;
    repeat (gap) @(posedge clk_i);
  endtask
  // head number equals slot for slots 1..n, so those modules are distinct
  task automatic number_heads(input int n);
    for (int s = 1; s <= n; s++) send_rec(4'(s), PID_HEAD_NUM, 16'(s), 1);
  endtask
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the image core
// Assumes: short blink half period, eight head slots
// Notes:   expectations come from bench functions, stored stimulus and constants
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fnpi_pkg::*;
  logic        clk_i, rst_i, link_up_i, rec_done_i, rec_valid_i, trigger_i, head_wr_i;
  logic        head_fault_i, node_fault_i, img_rd_i, img_word_i, img_valid_o, img_err_o;
  logic        ready_o, led_yellow_o, led_green_o;
  logic [2:0]  ao1_mode_o, ao2_mode_o;
  logic [3:0]  rec_slot_i, rec_id_i, head_slot_i, img_slot_i, heads_cnt_o;
  logic [7:0]  head_present_i;
  logic [8:0]  diag_fwd_o;
  logic [15:0] rec_data_i, head_obj_i, head_int_i, node_temp_i, img_data_o, ao1_bot_o;
  logic [15:0] ao1_top_o, ao1_temp_o, ao2_bot_o, ao2_top_o, ao2_temp_o, nt;
  logic [15:0] obj_e [1:8], int_e [1:8];
  int          n_mismatch = 0;
  int          checked = 0;
  int          seed, n, hi;

  fnpi_core #(.MAX_HEADS(8), .BLINK_HALF(4)) u_fnpi_core (.*);
  fnpi_ctrl_model u_fnpi_ctrl_model (.clk_i, .link_up_o(link_up_i), .rec_done_o(rec_done_i),
    .rec_valid_o(rec_valid_i), .rec_slot_o(rec_slot_i), .rec_id_o(rec_id_i),
    .rec_data_o(rec_data_i));

  always #5 clk_i = ~clk_i;

  function automatic int lead(input logic [7:0] v);
    int k;
    k = 0;
    while (k < 8 && v[k] === 1'b1) k++;
    return k;
  endfunction
  function automatic logic [15:0] to_f(input logic [15:0] c);
    return 16'($signed(c) * F_MUL / F_DIV + F_OFS);
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rec(input logic [3:0] s, input logic [3:0] id, input logic [15:0] d);
    u_fnpi_ctrl_model.send_rec(s, id, d, 0);
    #1;
  endtask
  task automatic hw(input logic [3:0] s, input logic f, input logic [15:0] o, input logic [15:0] i);
    @(posedge clk_i);
    {head_wr_i, head_slot_i, head_fault_i, head_obj_i, head_int_i} <= {1'b1, s, f, o, i};
    @(posedge clk_i);
    head_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] s, input logic w);
    @(posedge clk_i);
    {img_rd_i, img_slot_i, img_word_i} <= {1'b1, s, w};
    @(posedge clk_i);
    img_rd_i   <= 1'b0;
    wt;
    chk(16'(img_valid_o), 16'h0001);
  endtask
  task automatic wt;
    @(posedge clk_i);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    seed = 32'ha5ee_ab39;
    clk_i = 1'b0;
    rst_i = 1'b1;
    n = 3 + {$random(seed)} % 5;
    head_present_i = 8'((1 << n) - 1 | ({$random(seed)} << (n + 1)));
    {trigger_i, head_wr_i, head_fault_i, node_fault_i, img_rd_i, img_word_i} = 6'h20;
    {head_slot_i, img_slot_i, head_obj_i, head_int_i} = 40'h0;
    node_temp_i = 16'({$random(seed)} % 3000);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(16'(ao1_mode_o), 16'(AO1_TRISTATE));
    chk(16'(ao2_mode_o), 16'(AO2_TRISTATE));
    chk(ao2_top_o, TEMP_TOP_RST);
    u_fnpi_ctrl_model.set_link(1'b1, 1'b0);
    repeat (20) wt;
    chk(16'(heads_cnt_o), 16'(lead(head_present_i)));
    hi = 0;
    repeat (16) begin
      wt;
      hi += led_green_o;
    end
    chk(16'(hi), 16'h0008);
    chk(16'(led_yellow_o), 16'h0001);
    rd(4'h1, 1'b0);
    chk(16'(img_err_o), 16'h0001);
    u_fnpi_ctrl_model.number_heads(n);
    for (int c = 0; c < 8; c++) begin
      rec(4'h0, PID_AO1_MODE, 16'(c));
      chk(16'(ao1_mode_o), (c > AO1_TRISTATE) ? 16'(AO1_TRISTATE) : 16'(c));
      rec(4'h0, PID_AO2_MODE, 16'(c));
      chk(16'(ao2_mode_o), (c > AO2_TRISTATE) ? 16'(AO2_TRISTATE) : 16'(c));
    end
    nt = 16'({$random(seed)} % 3000);
    rec(4'h0, PID_AO1_BOT, nt);
    chk(ao1_bot_o, nt);
    rec(4'h0, PID_AO1_TOP, ~nt);
    chk(ao1_top_o, ~nt);
    rec(4'h0, PID_AO1_HEAD, 16'h0001);
    rec(4'h0, PID_AO1_TYPE, 16'h0001);
    rec(4'h0, PID_AO2_HEAD, 16'(n));
    rec(4'h0, PID_AO2_TYPE, 16'h0000);
    u_fnpi_ctrl_model.set_link(1'b1, 1'b1);
    for (int w = 0; w < 10 && ready_o !== 1'b1; w++) wt;
    chk({14'h0, led_yellow_o, led_green_o}, 16'h0003);
    for (int s = 1; s <= n; s++) begin
      obj_e[s] = 16'({$random(seed)} % 3000);
      int_e[s] = 16'({$random(seed)} % 800);
      hw(4'(s), 1'b0, obj_e[s], int_e[s]);
    end
    wt;
    chk(ao1_temp_o, obj_e[1]);
    chk(ao2_temp_o, int_e[n]);
    for (int s = 1; s <= n + 1; s++) begin
      rd(4'(s), 1'b0);
      chk(img_data_o, (s > n) ? 16'h0000 : obj_e[s]);
      chk(16'(img_err_o), 16'(s > n));
      rd(4'(s), 1'b1);
      chk(img_data_o, (s > n) ? 16'h0000 : int_e[s]);
    end
    rd(4'h0, 1'b0);
    chk(img_data_o, node_temp_i);
    rd(4'h0, 1'b1);
    chk(img_data_o, 16'h0001);
    rec(4'h0, PID_UNIT, 16'h0001);
    hw(4'h1, 1'b0, obj_e[1], int_e[1]);
    rd(4'h1, 1'b1);
    chk(img_data_o, to_f(int_e[1]));
    rec(4'h0, PID_UNIT, 16'h0000);
    rec(4'h2, PID_MOD_FAULT, 16'h0001);
    for (int s = 1; s <= 3; s++) hw(4'(s), 1'b1, 16'h0123, 16'h0045);
    rd(4'h1, 1'b1);
    chk(img_data_o, 16'h0000);
    rd(4'h2, 1'b0);
    chk(img_data_o, obj_e[2]);
    rd(4'h3, 1'b0);
    chk(img_data_o, 16'h0000);
    chk(16'(diag_fwd_o[1]), 16'h0000);
    rec(4'h0, PID_PDIAG, 16'h0001);
    wt;
    chk(16'(diag_fwd_o[1]), 16'h0001);
    rec(4'h1, PID_MOD_DIAG, 16'h0000);
    node_fault_i <= 1'b1;
    wt;
    chk(16'(diag_fwd_o[3:0]), 16'h000C);
    rec(4'h0, PID_NODE_DIAG, 16'h0001);
    wt;
    chk(16'(diag_fwd_o[0]), 16'h0001);
    u_fnpi_ctrl_model.set_link(1'b0, 1'b0);
    repeat (3) wt;
    chk({14'h0, led_yellow_o, led_green_o}, 16'h0000);
    end_sim;
  end
endmodule
